// ---- design/pdtc_cfg.svh ----
// offsets, field positions, reset values and write masks of the dsp and tdr configuration bank
`ifndef PDTC_CFG_SVH
`define PDTC_CFG_SVH

// extended register addresses
`define PDTC_ADDR_ENERGY_WD     16'h0101
`define PDTC_ADDR_ENERGY_WIN    16'h010a
`define PDTC_ADDR_CONV_LIMIT    16'h0123
`define PDTC_ADDR_RETRAIN_WD    16'h0130
`define PDTC_ADDR_CABLE_DIAG    16'h0170
`define PDTC_ADDR_CABLE_DIAG2   16'h0171

// reset values
`define PDTC_RST_ENERGY_WD      16'h2082
`define PDTC_RST_ENERGY_WIN     16'h2040
`define PDTC_RST_CONV_LIMIT     16'h051c
`define PDTC_RST_RETRAIN_WD     16'h4f28
`define PDTC_RST_CABLE_DIAG     16'h0410

// writable bits; all others are reserved, read zero
`define PDTC_MASK_ENERGY_WD     16'hff9f
`define PDTC_MASK_ENERGY_WIN    16'hffff
`define PDTC_MASK_CONV_LIMIT    16'h7fff
`define PDTC_MASK_RETRAIN_WD    16'h7fff
`define PDTC_MASK_CABLE_DIAG    16'h7770

// energy/watchdog control fields
`define PDTC_LOSS_LVL_HI        15
`define PDTC_LOSS_LVL_LO        8
`define PDTC_DFE_FREEZE         7
`define PDTC_GUARD_OFF          4
`define PDTC_POOR_TMR_HI        3
`define PDTC_POOR_TMR_LO        1
`define PDTC_EDGE_ONLY          0
// energy window / on level fields
`define PDTC_WIN_LEN_HI         15
`define PDTC_WIN_LEN_LO         8
`define PDTC_ON_LVL_HI          7
`define PDTC_ON_LVL_LO          0
// convergence limit
`define PDTC_CONV_HI            14
`define PDTC_CONV_LO            0
// gain retrain / watchdog fields
`define PDTC_RETRAIN_HI         14
`define PDTC_RETRAIN_LO         12
`define PDTC_RETRAIN_BYP        11
`define PDTC_RETRAIN_STEP       10
`define PDTC_LOST_TRIG          9
`define PDTC_LOST_CLR           8
`define PDTC_GUARD_CNT_HI       7
`define PDTC_GUARD_CNT_LO       0
// cable diagnostic fields
`define PDTC_CROSS_DIS          14
`define PDTC_TX_PAIR            13
`define PDTC_KEEP_DC            12
`define PDTC_AVG_HI             10
`define PDTC_AVG_LO             8
`define PDTC_SEG_HI             6
`define PDTC_SEG_LO             4

// averaging codes
`define PDTC_AVG_RSVD           3'h7
`define PDTC_AVG_MAX            3'h6

`endif

// ---- design/pdtc_pkg.sv ----
// types shared by the dsp and tdr configuration bank
package pdtc_pkg;

	typedef logic [15:0] pdtc_word_t;

	typedef enum logic [2:0]
	{
		PDTC_SEG_RSVD0 = 3'b000,
		PDTC_SEG_0_10  = 3'b001,
		PDTC_SEG_10_20 = 3'b010,
		PDTC_SEG_20_40 = 3'b011,
		PDTC_SEG_40_80 = 3'b100,
		PDTC_SEG_80_UP = 3'b101,
		PDTC_SEG_RSVD6 = 3'b110,
		PDTC_SEG_RSVD7 = 3'b111
	} pdtc_seg_t;

	typedef enum logic
	{
		PDTC_PAIR_A = 1'b0,
		PDTC_PAIR_B = 1'b1
	} pdtc_pair_t;

	// masked write: reserved bits forced to zero
	function automatic pdtc_word_t pdtc_merge(input pdtc_word_t wdata, input pdtc_word_t mask);
		return wdata & mask;
	endfunction

	function automatic logic pdtc_seg_ok(input logic [2:0] code);
		return (code >= 3'b001) && (code <= 3'b101);
	endfunction

endpackage

// ---- design/pdtc_bank_if.sv ----
// write path and read-back words between the bank decoder and the storage modules
`timescale 1ns/1ps
`default_nettype none

interface pdtc_bank_if;
	import pdtc_pkg::*;

	logic        wr_en;
	logic [15:0] addr;
	pdtc_word_t  wdata;
	pdtc_word_t  energy_wd;
	pdtc_word_t  energy_win;
	pdtc_word_t  conv_limit;
	pdtc_word_t  retrain_wd;
	pdtc_word_t  cable_diag;

	modport decoder (output wr_en, output addr, output wdata,
		input energy_wd, input energy_win, input conv_limit, input retrain_wd, input cable_diag);
	modport dsp_bank (input wr_en, input addr, input wdata,
		output energy_wd, output energy_win, output conv_limit, output retrain_wd);
	modport tdr_bank (input wr_en, input addr, input wdata, output cable_diag);

endinterface

`default_nettype wire

// ---- design/pdtc_dsp_store.sv ----
// storage of the four 100m receive dsp configuration words
`include "pdtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pdtc_dsp_store
(
	input  wire logic ref_clk,         // core clock
	input  wire logic nrst,            // async reset, active low
	pdtc_bank_if.dsp_bank bus          // write path and read-back
);
	import pdtc_pkg::*;

	pdtc_word_t energy_wd_reg, energy_wd_next;
	pdtc_word_t energy_win_reg, energy_win_next;
	pdtc_word_t conv_limit_reg, conv_limit_next;
	pdtc_word_t retrain_wd_reg, retrain_wd_next;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		energy_wd_next  = energy_wd_reg;
		energy_win_next = energy_win_reg;
		conv_limit_next = conv_limit_reg;
		retrain_wd_next = retrain_wd_reg;
		if (bus.wr_en)
		begin
			unique case (bus.addr)
				`PDTC_ADDR_ENERGY_WD:  energy_wd_next  = pdtc_merge(bus.wdata, `PDTC_MASK_ENERGY_WD);
				`PDTC_ADDR_ENERGY_WIN: energy_win_next = pdtc_merge(bus.wdata, `PDTC_MASK_ENERGY_WIN);
				`PDTC_ADDR_CONV_LIMIT: conv_limit_next = pdtc_merge(bus.wdata, `PDTC_MASK_CONV_LIMIT);
				`PDTC_ADDR_RETRAIN_WD: retrain_wd_next = pdtc_merge(bus.wdata, `PDTC_MASK_RETRAIN_WD);
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			energy_wd_reg  <= `PDTC_RST_ENERGY_WD;
			energy_win_reg <= `PDTC_RST_ENERGY_WIN;
			conv_limit_reg <= `PDTC_RST_CONV_LIMIT;
			retrain_wd_reg <= `PDTC_RST_RETRAIN_WD;
		end
		else
		begin
			energy_wd_reg  <= energy_wd_next;
			energy_win_reg <= energy_win_next;
			conv_limit_reg <= conv_limit_next;
			retrain_wd_reg <= retrain_wd_next;
		end
	end

	assign bus.energy_wd  = energy_wd_reg;
	assign bus.energy_win = energy_win_reg;
	assign bus.conv_limit = conv_limit_reg;
	assign bus.retrain_wd = retrain_wd_reg;

endmodule

`default_nettype wire

// ---- design/pdtc_tdr_store.sv ----
// storage of the cable diagnostic control word
`include "pdtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pdtc_tdr_store
(
	input  wire logic ref_clk,         // core clock
	input  wire logic nrst,            // async reset, active low
	pdtc_bank_if.tdr_bank bus          // write path and read-back
);
	import pdtc_pkg::*;

	pdtc_word_t cable_diag_reg, cable_diag_next;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		cable_diag_next = cable_diag_reg;
		if (bus.wr_en && (bus.addr == `PDTC_ADDR_CABLE_DIAG))
			cable_diag_next = pdtc_merge(bus.wdata, `PDTC_MASK_CABLE_DIAG);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cable_diag_reg <= `PDTC_RST_CABLE_DIAG;
		else
			cable_diag_reg <= cable_diag_next;
	end

	assign bus.cable_diag = cable_diag_reg;

endmodule

`default_nettype wire

// ---- design/pdtc_config_bank.sv ----
// configuration bank for the 100m receive dsp and the cable reflectometry setup
//
// What this block does
// - holds 15-bit convergence error limit in bits 14-0, reset 0x51c
// - 3-bit gain retrain interval in bits 14-12, reset 0x4
// - gain retrain step select at bit 10, reset one
// - energy-lost trigger select at bit 9, reset one
// - energy-lost clear select at bit 8, reset one
// - bit 14 clear listens on other pair, set listens on transmit pair
// - bit 13 picks transmit pair, 0 is A, 1 is B, reset 0
// - bit 12 set keeps offset removal from resetting before a run
// - bits 10-8 give averaged runs as power of two, 7 reserved, reset 4
// - bits 6-4 pick cable segment 001b..101b, others reserved, reset 001b
`include "pdtc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pdtc_config_bank
(
	input  wire logic        ref_clk,                 // 200 mhz core clock
	input  wire logic        nrst,                    // async reset, active low
	// register access from the management block
	input  wire logic [15:0] reg_addr,                // extended register address
	input  wire logic        reg_wr,                  // write strobe, one cycle
	input  wire logic        reg_rd,                  // read strobe, one cycle
	input  wire logic [15:0] reg_wdata,               // write data
	output logic      [15:0] reg_rdata,               // read data, held until next read
	output logic             reg_rd_valid,            // read data valid pulse
	output logic             reg_rd_hit,              // last read hit a mapped address
	// 100m receive dsp configuration
	output logic       [7:0] signal_loss_level,       // energy lost threshold
	output logic             dfe_freeze,              // equaliser freeze control
	output logic             sequencer_guard_disable, // sequencer watchdog off
	output logic       [2:0] poor_error_timer_choice, // bad error timer select
	output logic             edge_only_detect_select, // energy detect edge only
	output logic       [7:0] energy_window_len,       // energy window length
	output logic       [7:0] signal_present_level,    // energy on threshold
	output logic      [14:0] convergence_error_limit, // error limit for convergence
	output logic       [2:0] gain_retrain_interval,   // retrain timer select
	output logic             gain_retrain_enable,     // retrain enable
	output logic             gain_retrain_step,       // retrain step select
	output logic             energy_lost_trigger,     // energy lost trigger select
	output logic             energy_lost_clear,       // energy lost clear select
	output logic       [7:0] sequencer_guard_count,   // watchdog count select
	// reflectometry configuration
	output pdtc_pkg::pdtc_pair_t tdr_tx_pair,         // transmitting pair
	output pdtc_pkg::pdtc_pair_t tdr_rx_pair,         // listening pair
	output logic             keep_offset_removal,     // no offset removal reset
	output logic       [6:0] tdr_avg_runs,            // runs averaged, 0 if reserved
	output logic             tdr_avg_reserved,        // reserved averaging code set
	output pdtc_pkg::pdtc_seg_t tdr_segment,          // selected cable segment
	output logic             tdr_segment_reserved     // reserved segment code set
);
	import pdtc_pkg::*;

	pdtc_bank_if bank ();

	////////////////////////////////////////////////////////////////////////////
	// storage
	assign bank.wr_en = reg_wr;
	assign bank.addr  = reg_addr;
	assign bank.wdata = reg_wdata;

	pdtc_dsp_store u_dsp
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.bus     (bank)
	);

	pdtc_tdr_store u_tdr
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.bus     (bank)
	);

	////////////////////////////////////////////////////////////////////////////
	// dsp outputs are slices of the storage flops
	assign signal_loss_level       = bank.energy_wd[`PDTC_LOSS_LVL_HI:`PDTC_LOSS_LVL_LO];
	assign dfe_freeze              = bank.energy_wd[`PDTC_DFE_FREEZE];
	assign sequencer_guard_disable = bank.energy_wd[`PDTC_GUARD_OFF];
	assign poor_error_timer_choice = bank.energy_wd[`PDTC_POOR_TMR_HI:`PDTC_POOR_TMR_LO];
	assign edge_only_detect_select = bank.energy_wd[`PDTC_EDGE_ONLY];
	assign energy_window_len       = bank.energy_win[`PDTC_WIN_LEN_HI:`PDTC_WIN_LEN_LO];
	assign signal_present_level    = bank.energy_win[`PDTC_ON_LVL_HI:`PDTC_ON_LVL_LO];
	assign convergence_error_limit = bank.conv_limit[`PDTC_CONV_HI:`PDTC_CONV_LO];
	assign gain_retrain_interval   = bank.retrain_wd[`PDTC_RETRAIN_HI:`PDTC_RETRAIN_LO];
	assign gain_retrain_enable     = bank.retrain_wd[`PDTC_RETRAIN_BYP];
	assign gain_retrain_step       = bank.retrain_wd[`PDTC_RETRAIN_STEP];
	assign energy_lost_trigger     = bank.retrain_wd[`PDTC_LOST_TRIG];
	assign energy_lost_clear       = bank.retrain_wd[`PDTC_LOST_CLR];
	assign sequencer_guard_count   = bank.retrain_wd[`PDTC_GUARD_CNT_HI:`PDTC_GUARD_CNT_LO];

	////////////////////////////////////////////////////////////////////////////
	// reflectometry outputs straight from the stored word
	assign tdr_tx_pair          = pdtc_pair_t'(bank.cable_diag[`PDTC_TX_PAIR]);
	assign keep_offset_removal  = bank.cable_diag[`PDTC_KEEP_DC];
	assign tdr_segment          = pdtc_seg_t'(bank.cable_diag[`PDTC_SEG_HI:`PDTC_SEG_LO]);

	// derived flags are registered from the next stored value so they track the word
	// in the same cycle instead of one cycle late
	pdtc_word_t diag_next;
	pdtc_pair_t rx_pair_reg, rx_pair_next;
	logic [6:0] avg_runs_reg, avg_runs_next;
	logic       avg_rsvd_reg, avg_rsvd_next;
	logic       seg_rsvd_reg, seg_rsvd_next;

	always_comb
	begin
		diag_next = bank.cable_diag;
		if (reg_wr && (reg_addr == `PDTC_ADDR_CABLE_DIAG))
			diag_next = pdtc_merge(reg_wdata, `PDTC_MASK_CABLE_DIAG);
		// cross mode listens on the other pair; same mode on the transmit pair
		if (diag_next[`PDTC_CROSS_DIS])
			rx_pair_next = pdtc_pair_t'(diag_next[`PDTC_TX_PAIR]);
		else
			rx_pair_next = pdtc_pair_t'(~diag_next[`PDTC_TX_PAIR]);
		avg_rsvd_next = (diag_next[`PDTC_AVG_HI:`PDTC_AVG_LO] == `PDTC_AVG_RSVD);
		// reserved code gives no count rather than an invented one
		if (avg_rsvd_next)
			avg_runs_next = 7'h00;
		else
			avg_runs_next = 7'h01 << diag_next[`PDTC_AVG_HI:`PDTC_AVG_LO];
		seg_rsvd_next = !pdtc_seg_ok(diag_next[`PDTC_SEG_HI:`PDTC_SEG_LO]);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_pair_reg  <= PDTC_PAIR_B;  // reset: cross mode, transmit on a
			avg_runs_reg <= 7'h10;        // reset code 4
			avg_rsvd_reg <= 1'b0;
			seg_rsvd_reg <= 1'b0;
		end
		else
		begin
			rx_pair_reg  <= rx_pair_next;
			avg_runs_reg <= avg_runs_next;
			avg_rsvd_reg <= avg_rsvd_next;
			seg_rsvd_reg <= seg_rsvd_next;
		end
	end

	assign tdr_rx_pair          = rx_pair_reg;
	assign tdr_avg_runs         = avg_runs_reg;
	assign tdr_avg_reserved     = avg_rsvd_reg;
	assign tdr_segment_reserved = seg_rsvd_reg;

	////////////////////////////////////////////////////////////////////////////
	// read-back; unmapped and reserved words read zero
	logic [15:0] rdata_reg, rdata_next;
	logic        rd_valid_reg, rd_valid_next;
	logic        rd_hit_reg, rd_hit_next;

	always_comb
	begin
		rdata_next    = rdata_reg;
		rd_hit_next   = rd_hit_reg;
		rd_valid_next = reg_rd;
		if (reg_rd)
		begin
			rd_hit_next = 1'b1;
			unique case (reg_addr)
				`PDTC_ADDR_ENERGY_WD:  rdata_next = bank.energy_wd;
				`PDTC_ADDR_ENERGY_WIN: rdata_next = bank.energy_win;
				`PDTC_ADDR_CONV_LIMIT: rdata_next = bank.conv_limit;
				`PDTC_ADDR_RETRAIN_WD: rdata_next = bank.retrain_wd;
				`PDTC_ADDR_CABLE_DIAG: rdata_next = bank.cable_diag;
				`PDTC_ADDR_CABLE_DIAG2: rdata_next = 16'h0000;
				default:
				begin
					rdata_next  = 16'h0000;
					rd_hit_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_reg    <= 16'h0000;
			rd_valid_reg <= 1'b0;
			rd_hit_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg    <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			rd_hit_reg   <= rd_hit_next;
		end
	end

	assign reg_rdata    = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;
	assign reg_rd_hit   = rd_hit_reg;

endmodule

`default_nettype wire

// ---- tb/pdtc_config_bank_monitor.sv ----
// assertion checker for the configuration bank ports
`timescale 1ns/1ps
`default_nettype none

module pdtc_config_bank_monitor
(
	input wire logic                 ref_clk,                 // clock
	input wire logic                 nrst,                    // reset
	input wire logic [15:0]          reg_addr,                // address
	input wire logic                 reg_wr,                  // write
	input wire logic                 reg_rd,                  // read
	input wire logic [15:0]          reg_wdata,               // write data
	input wire logic [15:0]          reg_rdata,               // read data
	input wire logic                 reg_rd_valid,            // read answer
	input wire logic                 reg_rd_hit,              // mapped read
	input wire logic [14:0]          convergence_error_limit, // limit
	input wire logic [2:0]           gain_retrain_interval,   // interval
	input wire logic                 gain_retrain_step,       // step
	input wire logic                 energy_lost_trigger,     // trigger
	input wire logic                 energy_lost_clear,       // clear
	input wire pdtc_pkg::pdtc_pair_t tdr_tx_pair,             // tx pair
	input wire pdtc_pkg::pdtc_pair_t tdr_rx_pair,             // rx pair
	input wire logic                 keep_offset_removal,     // keep dc
	input wire logic [6:0]           tdr_avg_runs,            // runs
	input wire logic                 tdr_avg_reserved,        // avg flag
	input wire pdtc_pkg::pdtc_seg_t  tdr_segment,             // segment
	input wire logic                 tdr_segment_reserved     // seg flag
);
	import pdtc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////
	sequence s_conv_wr;
		reg_wr && reg_addr == 16'h0123;
	endsequence
	sequence s_retrain_wr;
		reg_wr && reg_addr == 16'h0130;
	endsequence
	sequence s_diag_wr;
		reg_wr && reg_addr == 16'h0170;
	endsequence

	a_conv_limit_load: assert property (s_conv_wr |=> convergence_error_limit == $past(reg_wdata[14:0]))
		else $error("convergence limit not loaded");
	a_retrain_fields_load: assert property (s_retrain_wr |=> {gain_retrain_interval, gain_retrain_step,
		energy_lost_trigger, energy_lost_clear} == {$past(reg_wdata[14:12]), $past(reg_wdata[10:8])})
		else $error("retrain fields not loaded");
	a_rx_pair_follow: assert property (s_diag_wr |=> tdr_rx_pair == ($past(reg_wdata[13]) ^ !$past(reg_wdata[14])))
		else $error("listening pair wrong");
	a_tx_pair_load: assert property (s_diag_wr |=> tdr_tx_pair == $past(reg_wdata[13]))
		else $error("transmit pair wrong");
	a_keep_offset_load: assert property (s_diag_wr |=> keep_offset_removal == $past(reg_wdata[12]))
		else $error("offset removal keep wrong");
	a_avg_runs_decode: assert property (s_diag_wr |=> tdr_avg_reserved == ($past(reg_wdata[10:8]) == 3'h7)
		&& tdr_avg_runs == (($past(reg_wdata[10:8]) == 3'h7) ? 7'h00 : 7'h01 << $past(reg_wdata[10:8])))
		else $error("averaging decode wrong");
	a_segment_decode: assert property (s_diag_wr |=> tdr_segment == $past(reg_wdata[6:4])
		&& tdr_segment_reserved == !($past(reg_wdata[6:4]) inside {[3'h1:3'h5]}))
		else $error("segment decode wrong");
	a_conv_limit_hold: assert property (!(reg_wr && reg_addr == 16'h0123) |=> $stable(convergence_error_limit))
		else $error("convergence limit changed without write");
	a_read_old_value: assert property (reg_rd && reg_addr == 16'h0123 |=> reg_rd_valid && reg_rd_hit
		&& reg_rdata == {1'b0, $past(convergence_error_limit)})
		else $error("limit read back wrong");
	a_unmapped_read_zero: assert property (reg_rd && !(reg_addr inside {16'h0101, 16'h010a, 16'h0123,
		16'h0130, 16'h0170, 16'h0171}) |=> reg_rd_valid && !reg_rd_hit && reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule

bind pdtc_config_bank pdtc_config_bank_monitor i_pdtc_config_bank_monitor
(
	.ref_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_rd_hit,
	.convergence_error_limit, .gain_retrain_interval, .gain_retrain_step, .energy_lost_trigger,
	.energy_lost_clear, .tdr_tx_pair, .tdr_rx_pair, .keep_offset_removal, .tdr_avg_runs,
	.tdr_avg_reserved, .tdr_segment, .tdr_segment_reserved
);

`default_nettype wire

// ---- tb/pdtc_mgmt_model.sv ----
// management side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none

module pdtc_mgmt_model
(
	input  wire logic        ref_clk,      // clock
	output logic      [15:0] reg_addr,     // address
	output logic             reg_wr,       // write strobe
	output logic             reg_rd,       // read strobe
	output logic      [15:0] reg_wdata,    // write data
	input  wire logic [15:0] reg_rdata,    // read data
	input  wire logic        reg_rd_valid, // read answer
	input  wire logic        reg_rd_hit    // mapped read
);
	initial
	begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////
	// released lines flip so a stale value never passes for a held one
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// answer comes one cycle after the strobe, so one cycle is all we wait
	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic hit, output logic ok);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		ok = reg_rd_valid;
		d = reg_rdata;
		hit = reg_rd_hit;
	endtask
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	import pdtc_pkg::*;
	logic        ref_clk, nrst, reg_wr, reg_rd, reg_rd_valid, reg_rd_hit;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [7:0]  signal_loss_level, energy_window_len, signal_present_level, sequencer_guard_count;
	logic        dfe_freeze, sequencer_guard_disable, edge_only_detect_select, gain_retrain_enable;
	logic        gain_retrain_step, energy_lost_trigger, energy_lost_clear, keep_offset_removal;
	logic        tdr_avg_reserved, tdr_segment_reserved;
	logic [2:0]  poor_error_timer_choice, gain_retrain_interval;
	logic [14:0] convergence_error_limit;
	logic [6:0]  tdr_avg_runs;
	pdtc_pair_t  tdr_tx_pair, tdr_rx_pair;
	pdtc_seg_t   tdr_segment;
	int          err_total = 0;
	int          n_tests = 0;
	localparam logic [15:0] addr_tab [6] = '{16'h0101, 16'h010a, 16'h0123, 16'h0130, 16'h0170, 16'h0171};
	localparam logic [15:0] rst_tab [6] = '{16'h2082, 16'h2040, 16'h051c, 16'h4f28, 16'h0410, 16'h0000};
	localparam logic [15:0] mask_tab [6] = '{16'hff9f, 16'hffff, 16'h7fff, 16'h7fff, 16'h7770, 16'h0000};

	pdtc_mgmt_model i_pdtc_mgmt_model
	(
		.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_rd_hit
	);
	pdtc_config_bank i_pdtc_config_bank
	(
		.ref_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_rd_hit,
		.signal_loss_level, .dfe_freeze, .sequencer_guard_disable, .poor_error_timer_choice,
		.edge_only_detect_select, .energy_window_len, .signal_present_level, .convergence_error_limit,
		.gain_retrain_interval, .gain_retrain_enable, .gain_retrain_step, .energy_lost_trigger,
		.energy_lost_clear, .sequencer_guard_count, .tdr_tx_pair, .tdr_rx_pair, .keep_offset_removal,
		.tdr_avg_runs, .tdr_avg_reserved, .tdr_segment, .tdr_segment_reserved
	);
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the dsp outputs other than the convergence limit packed back into their register words, reserved bits as zero
	task automatic dsp_outs_chk(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
		chk({signal_loss_level, dfe_freeze, 2'b00, sequencer_guard_disable,
			poor_error_timer_choice, edge_only_detect_select}, e0, "energy outputs");
		chk({energy_window_len, signal_present_level}, e1, "window outputs");
		chk({1'b0, gain_retrain_interval, gain_retrain_enable, gain_retrain_step,
			energy_lost_trigger, energy_lost_clear, sequencer_guard_count}, e2, "retrain outputs");
	endtask

	task automatic read_chk(input logic [15:0] a, input logic [15:0] exp, input logic hit_exp);
		logic [15:0] d;
		logic        hit, ok;
		i_pdtc_mgmt_model.rd(a, d, hit, ok);
		chk({15'h0, ok}, 16'h0001, "read answer");
		if (ok !== 1'b1)
			tally_and_finish();
		chk(d, exp, "read data");
		chk({15'h0, hit}, {15'h0, hit_exp}, "read hit");
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		for (int i = 0; i < 6; i++)
			read_chk(addr_tab[i], rst_tab[i], 1'b1);
		chk({9'h0, tdr_avg_runs}, 16'h0010, "avg runs");
		chk({15'h0, tdr_tx_pair}, 16'h0000, "tx pair");
		chk({15'h0, tdr_rx_pair}, 16'h0001, "rx pair");
		chk({13'h0, tdr_segment}, 16'h0001, "segment");
		chk({15'h0, keep_offset_removal}, 16'h0000, "keep offset");
		chk({14'h0, tdr_avg_reserved, tdr_segment_reserved}, 16'h0000, "reserved flags");
		dsp_outs_chk(16'h2082, 16'h2040, 16'h4f28);
		$display("reset values done");
	endtask

	task automatic t_masks_and_holes;
		for (int i = 0; i < 6; i++)
			i_pdtc_mgmt_model.wr(addr_tab[i], 16'hffff);
		i_pdtc_mgmt_model.wr(16'h0102, 16'h0000);
		read_chk(16'h0102, 16'h0000, 1'b0);
		for (int i = 0; i < 6; i++)
			read_chk(addr_tab[i], mask_tab[i], 1'b1);
		chk({1'b0, convergence_error_limit}, 16'h7fff, "limit");
		chk({8'h0, sequencer_guard_count}, 16'h00ff, "guard count");
		dsp_outs_chk(16'hff9f, 16'hffff, 16'h7fff);
		i_pdtc_mgmt_model.wr(16'h0123, 16'h1234);
		nrst = 1'b0;
		@(negedge ref_clk);
		nrst = 1'b1;
		read_chk(16'h0123, 16'h051c, 1'b1);
		$display("masks and holes done");
	endtask

	task automatic t_avg_and_segment;
		for (int c = 0; c < 8; c++)
		begin
			i_pdtc_mgmt_model.wr(16'h0170, {5'h0, c[2:0], 8'h10});
			chk({9'h0, tdr_avg_runs}, (c == 7) ? 16'h0000 : 16'h0001 << c, "avg runs");
			chk({15'h0, tdr_avg_reserved}, {15'h0, c == 7}, "avg flag");
			i_pdtc_mgmt_model.wr(16'h0170, {9'h0, c[2:0], 4'h0});
			chk({13'h0, tdr_segment}, {13'h0, c[2:0]}, "segment");
			chk({15'h0, tdr_segment_reserved}, {15'h0, c == 0 || c > 5}, "segment flag");
			read_chk(16'h0170, {9'h0, c[2:0], 4'h0}, 1'b1);
		end
		$display("averaging and segment done");
	endtask

	task automatic t_pair_modes;
		for (int m = 0; m < 8; m++)
		begin
			i_pdtc_mgmt_model.wr(16'h0170, {1'b0, m[2:0], 12'h410});
			chk({15'h0, tdr_tx_pair}, {15'h0, m[1]}, "tx pair");
			chk({15'h0, tdr_rx_pair}, {15'h0, m[2] ? m[1] : !m[1]}, "rx pair");
			chk({15'h0, keep_offset_removal}, {15'h0, m[0]}, "keep offset");
		end
		$display("pair modes done");
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial
	begin
		nrst = 1'b0;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		t_reset_values();
		t_masks_and_holes();
		t_avg_and_segment();
		t_pair_modes();
		tally_and_finish();
	end
endmodule

`default_nettype wire
